// File: rtl/ccl_pkg.sv
// Shared constants for the configurable lookup logic block
package ccl_pkg;
    // Write port offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_SEQ = 4'h1;
    localparam logic [3:0] OFS_LUT_BASE = 4'h5;
    localparam logic [3:0] OFS_LUT_STRIDE = 4'h4;
    localparam logic [3:0] OFS_CTRL_A = 4'h0;
    localparam logic [3:0] OFS_CTRL_B = 4'h1;
    localparam logic [3:0] OFS_CTRL_C = 4'h2;
    localparam logic [3:0] OFS_TRUTH = 4'h3;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_SEQ = 4'h0;
    // Field positions in control A
    localparam int A_EN = 0;
    localparam int A_OUTEN = 3;
    localparam int A_FILT_LO = 4;
    localparam int A_TABLE_CLOCK_SELECT = 6;
    localparam int A_EDGE = 7;
    // Global control field
    localparam int G_EN = 0;
    // Sequential function codes
    localparam logic [3:0] SEQ_OFF = 4'h0;
    localparam logic [3:0] SEQ_DFF = 4'h1;
    localparam logic [3:0] SEQ_JK = 4'h2;
    localparam logic [3:0] SEQ_LATCH = 4'h3;
    localparam logic [3:0] SEQ_RS = 4'h4;
    // Output filter codes
    localparam logic [1:0] FLT_OFF = 2'h0;
    localparam logic [1:0] FLT_SYNC = 2'h1;
    localparam logic [1:0] FLT_FILTER = 2'h2;
    // Input source codes
    localparam logic [3:0] SRC_MASK = 4'h0;
    localparam logic [3:0] SRC_FEEDBACK = 4'h1;
    localparam logic [3:0] SRC_LINK = 4'h2;
    localparam logic [3:0] SRC_EVENT_A = 4'h3;
    localparam logic [3:0] SRC_EVENT_B = 4'h4;
    localparam logic [3:0] SRC_PIN = 4'h5;
    localparam logic [3:0] SRC_PERIPH0 = 4'h6;
    localparam int PERIPH_W = 4;
    // Filter history depth and synchronizer tap
    localparam int FILT_DEPTH = 4;
    localparam int SYNC_TAP = 1;
    localparam int NUM_LUT = 2;
endpackage : ccl_pkg

// File: rtl/ccl_lut_if.sv
// Carrier between the top and one lookup table unit
`timescale 1ns/1ps
`default_nettype none
interface ccl_lut_if;
    logic en;           // Effective table enable
    logic [7:0] ctrl_a; // Control A image
    logic [7:0] truth;  // Truth bits
    logic [2:0] in;     // Resolved table inputs
    logic direct;       // Raw truth output
    logic out;          // Filtered and edge path output
    logic tick;         // Selected table clock edge
    modport lut (input en, ctrl_a, truth, in, output direct, out, tick);
    modport top (output en, ctrl_a, truth, in, input direct, out, tick);
endinterface : ccl_lut_if
`default_nettype wire

// File: rtl/ccl_lut.sv
// One lookup table with truth evaluation, filter and edge detector
`timescale 1ns/1ps
`default_nettype none
module ccl_lut (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    ccl_lut_if.lut lb
);
    import ccl_pkg::*;

    logic en_q;                    // Enable seen one cycle late
    logic in2_q;                   // Previous input 2 for clock edge
    logic [FILT_DEPTH-1:0] hist;   // Filter history
    logic filt_val;                // Filter agreed value
    logic edge_prev;               // Edge detector memory
    logic stage;                   // Output of filter option
    logic [1:0] fsel;              // Filter select field

    assign fsel = lb.ctrl_a[A_FILT_LO+1:A_FILT_LO];

    // Truth bit indexed by the inputs
    assign lb.direct = lb.truth[lb.in];

    // Selected table clock: peripheral clock or rising input 2
    assign lb.tick = lb.ctrl_a[A_TABLE_CLOCK_SELECT] ? (lb.in[2] & ~in2_q) : 1'b1;

    // Delayed enable and input 2 history
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            en_q <= 1'b0;
            in2_q <= 1'b0;
        end else begin
            en_q <= lb.en;
            in2_q <= lb.in[2];
        end
    end

    // Filter history, cleared a cycle after disable
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || !en_q) begin
            hist <= '0;
            filt_val <= 1'b0;
        end else if (lb.tick) begin
            hist <= {hist[FILT_DEPTH-2:0], lb.direct};
            // Output moves only when three samples agree
            if (hist[1] == hist[2] && hist[2] == hist[3]) begin
                filt_val <= hist[3];
            end
        end
    end

    // Filter option select
    always_comb begin
        case (fsel)
            FLT_SYNC: stage = hist[SYNC_TAP];
            FLT_FILTER: stage = filt_val;
            default: stage = lb.direct;
        endcase
    end

    // Edge detector memory, cleared a cycle after disable
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || !en_q) begin
            edge_prev <= 1'b0;
        end else if (lb.tick) begin
            edge_prev <= stage;
        end
    end

    // Final output: rising edge pulse or filtered level
    assign lb.out = !lb.en ? 1'b0 :
        (lb.ctrl_a[A_EDGE] ? (stage & ~edge_prev) : stage);

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    a_edge_one_pulse:
    assert property (lb.en && lb.ctrl_a[A_EDGE] && lb.out |=> !lb.out || !lb.tick || !$stable(lb.ctrl_a))
        else $error("edge pulse lasted two ticks");
    a_sync_two_cycles:
    assert property (lb.en [*4] ##0 (fsel == FLT_SYNC && !lb.ctrl_a[A_TABLE_CLOCK_SELECT] && !lb.ctrl_a[A_EDGE])
                     |-> lb.out == $past(lb.direct, 2))
        else $error("synchronizer delay not two cycles");
    a_filter_clear:
    assert property (!lb.en ##1 1'b1 |=> hist == '0 && !filt_val && !edge_prev)
        else $error("filter state not cleared after disable");
endmodule : ccl_lut
`default_nettype wire

// File: rtl/ccl_top.sv
// Configurable lookup logic: two tables, input routing and sequential element
// Contract
// - sequential select writable only while even table off
// - table controls locked except enable while on
// - protected bits accepted with enabling, not disabling write
// - global and per table enable bits
// - output equals truth bit indexed by inputs
// - masked input reads low
// - inputs 0,1 from control B, 2 from C
// - feedback input takes pair registered sequential state
// - link input takes next table direct output; the last table's link input reads low
// - two event lines selectable as inputs
// - pin option uses table's dedicated input pin
// - filter delays two to five; cleared after disable
// - edge detector pulses on rising edge
// - edge detector cleared one cycle after disable
// - sequential uses table clock and filtered paths
// - sequential cleared while even table disabled
// - flip-flop loads data when gate high
// - jk holds, clears, sets, toggles
// - latch transparent while gate high
// - rs latch sets and clears, both forbidden
// - sequential select codes zero to four
// - clock select peripheral clock or input 2
// - filter select codes off, sync, filter
// - table outputs are events, events are inputs
`timescale 1ns/1ps
`default_nettype none
module ccl_top (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_wr,
    input wire logic [3:0] i_wr_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic [3:0] i_rd_addr,
    output logic [7:0] o_rd_data,
    input wire logic i_event_line_a,
    input wire logic i_event_line_b,
    input wire logic [5:0] i_table_pin,
    input wire logic [7:0] i_periph,
    output logic [1:0] o_table_output_event,
    output logic [1:0] o_pin_out,
    output logic [1:0] o_pin_oe,
    output logic o_sequential_output
);
    import ccl_pkg::*;

    logic glob_en;                      // Global enable
    logic [3:0] seq_sel;                // Sequential function select
    logic [7:0] ctrl_a [NUM_LUT];       // Table control A
    logic [7:0] ctrl_b [NUM_LUT];       // Table control B
    logic [7:0] ctrl_c [NUM_LUT];       // Table control C
    logic [7:0] truth [NUM_LUT];        // Truth bits
    logic [7:0] s1, s2, s3;             // Three stage pin and event sync
    logic [7:0] clean;                  // Debounced external inputs
    logic [NUM_LUT-1:0] lut_en;         // Effective table enables
    logic [NUM_LUT-1:0] lut_out;        // Table outputs
    logic [NUM_LUT-1:0] lut_direct;     // Raw truth outputs
    logic [NUM_LUT-1:0] lut_tick;       // Table clock edges
    logic seq_q;                        // Sequential state
    logic seq_out;                      // Sequential output
    logic next_seq;                     // Next sequential state

    ccl_lut_if lif [NUM_LUT] ();

    // Decode of one input source
    function automatic logic src_pick(input logic [3:0] sel, input logic fb, input logic link,
                                      input logic eva, input logic evb, input logic pin,
                                      input logic [PERIPH_W-1:0] per);
        logic [3:0] pidx;
        pidx = sel - SRC_PERIPH0;
        case (sel)
            SRC_MASK: src_pick = 1'b0;
            SRC_FEEDBACK: src_pick = fb;
            SRC_LINK: src_pick = link;
            SRC_EVENT_A: src_pick = eva;
            SRC_EVENT_B: src_pick = evb;
            SRC_PIN: src_pick = pin;
            default: begin
                if (sel >= SRC_PERIPH0 && pidx < 4'(PERIPH_W)) begin
                    src_pick = per[pidx[1:0]];
                end else begin
                    src_pick = 1'b0;
                end
            end
        endcase
    endfunction : src_pick

    // Decode helper: whether an offset hits the given register of table n
    function automatic logic lut_hit(input logic [3:0] addr, input int n, input logic [3:0] reg_ofs);
        lut_hit = addr == 4'(OFS_LUT_BASE + 4'(n) * OFS_LUT_STRIDE + reg_ofs);
    endfunction : lut_hit

    // Global control and sequential select
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            glob_en <= 1'b0;
            seq_sel <= RST_SEQ;
        end else if (i_wr) begin
            if (i_wr_addr == OFS_CTRL) begin
                glob_en <= i_wr_data[G_EN];
            end
            // Ignored while the even table is on
            if (i_wr_addr == OFS_SEQ && !ctrl_a[0][A_EN]) begin
                seq_sel <= i_wr_data[3:0];
            end
        end
    end

    // Per table control writes with enable protection
    generate
        for (genvar n = 0; n < NUM_LUT; n++) begin : g_regs
            always_ff @(posedge i_clk) begin
                if (i_sys_rst) begin
                    ctrl_a[n] <= RST_BYTE;
                    ctrl_b[n] <= RST_BYTE;
                    ctrl_c[n] <= RST_BYTE;
                    truth[n] <= RST_BYTE;
                end else if (i_wr) begin
                    if (lut_hit(i_wr_addr, n, OFS_CTRL_A)) begin
                        if (!ctrl_a[n][A_EN]) begin
                            ctrl_a[n] <= i_wr_data;
                        end else begin
                            ctrl_a[n][A_EN] <= i_wr_data[A_EN];
                        end
                    end
                    if (lut_hit(i_wr_addr, n, OFS_CTRL_B) && !ctrl_a[n][A_EN]) begin
                        ctrl_b[n] <= i_wr_data;
                    end
                    if (lut_hit(i_wr_addr, n, OFS_CTRL_C) && !ctrl_a[n][A_EN]) begin
                        ctrl_c[n] <= i_wr_data;
                    end
                    if (lut_hit(i_wr_addr, n, OFS_TRUTH)) begin
                        truth[n] <= i_wr_data;
                    end
                end
            end
        end
    endgenerate

    // Register readback, one cycle after the address
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_rd_data <= RST_BYTE;
        end else begin
            o_rd_data <= RST_BYTE;
            if (i_rd_addr == OFS_CTRL) begin
                o_rd_data <= {7'h00, glob_en};
            end else if (i_rd_addr == OFS_SEQ) begin
                o_rd_data <= {4'h0, seq_sel};
            end
            for (int n = 0; n < NUM_LUT; n++) begin
                if (lut_hit(i_rd_addr, n, OFS_CTRL_A)) begin
                    o_rd_data <= ctrl_a[n];
                end else if (lut_hit(i_rd_addr, n, OFS_CTRL_B)) begin
                    o_rd_data <= ctrl_b[n];
                end else if (lut_hit(i_rd_addr, n, OFS_CTRL_C)) begin
                    o_rd_data <= ctrl_c[n];
                end else if (lut_hit(i_rd_addr, n, OFS_TRUTH)) begin
                    o_rd_data <= truth[n];
                end
            end
        end
    end

    // Pin and event synchronizer; a change counts when stages two and three agree
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            s1 <= 8'h00;
            s2 <= 8'h00;
            s3 <= 8'h00;
            clean <= 8'h00;
        end else begin
            s1 <= {i_event_line_b, i_event_line_a, i_table_pin};
            s2 <= s1;
            s3 <= s2;
            clean <= (s2 & s3) | (clean & (s2 ^ s3));
        end
    end

    // Table units and their input routing
    generate
        for (genvar n = 0; n < NUM_LUT; n++) begin : g_lut
            logic link_in;
            assign link_in = (n + 1 < NUM_LUT) ? lut_direct[(n + 1) % NUM_LUT] : 1'b0;
            assign lut_en[n] = glob_en & ctrl_a[n][A_EN];
            assign lif[n].en = lut_en[n];
            assign lif[n].ctrl_a = ctrl_a[n];
            assign lif[n].truth = truth[n];
            // Inputs 0 and 1 from control B, input 2 from control C
            assign lif[n].in[0] = src_pick(ctrl_b[n][3:0], seq_q, link_in, clean[6], clean[7],
                                           clean[3*n], i_periph[4*n +: PERIPH_W]);
            assign lif[n].in[1] = src_pick(ctrl_b[n][7:4], seq_q, link_in, clean[6], clean[7],
                                           clean[3*n+1], i_periph[4*n +: PERIPH_W]);
            assign lif[n].in[2] = src_pick(ctrl_c[n][3:0], seq_q, link_in, clean[6], clean[7],
                                           clean[3*n+2], i_periph[4*n +: PERIPH_W]);
            assign lut_out[n] = lif[n].out;
            assign lut_direct[n] = lif[n].direct;
            assign lut_tick[n] = lif[n].tick;
            ccl_lut u_lut (
                .i_clk(i_clk),
                .i_sys_rst(i_sys_rst),
                .lb(lif[n])
            );
        end
    endgenerate

    // Next state of the sequential element, even table data, J or set, odd table gate, K or reset
    always_comb begin
        next_seq = seq_q;
        case (seq_sel)
            SEQ_DFF: begin
                if (lut_tick[0] && lut_out[1]) begin
                    next_seq = lut_out[0];
                end
            end
            SEQ_JK: begin
                if (lut_tick[0]) begin
                    case ({lut_out[0], lut_out[1]})
                        2'b01: next_seq = 1'b0;
                        2'b10: next_seq = 1'b1;
                        2'b11: next_seq = ~seq_q;
                        default: next_seq = seq_q;
                    endcase
                end
            end
            SEQ_LATCH: next_seq = lut_out[1] ? lut_out[0] : seq_q;
            SEQ_RS: begin
                if (lut_out[0] && !lut_out[1]) begin
                    next_seq = 1'b1;
                end else if (lut_out[1] && !lut_out[0]) begin
                    next_seq = 1'b0;
                end else begin
                    next_seq = seq_q;
                end
            end
            default: next_seq = 1'b0;
        endcase
    end

    // Sequential state, held clear while the even table is off
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || !lut_en[0]) begin
            seq_q <= 1'b0;
        end else begin
            seq_q <= next_seq;
        end
    end

    // Latch modes are transparent; flip-flop modes show the state
    assign seq_out = !lut_en[0] ? 1'b0 :
        (seq_sel == SEQ_LATCH || seq_sel == SEQ_RS) ? next_seq : seq_q;

    // Event and pin outputs; the pair sequential output replaces the even table
    assign o_table_output_event[0] = (seq_sel == SEQ_OFF) ? lut_out[0] : seq_out;
    assign o_table_output_event[1] = lut_out[1];
    assign o_pin_out = o_table_output_event;
    assign o_pin_oe = {lut_en[1] & ctrl_a[1][A_OUTEN], lut_en[0] & ctrl_a[0][A_OUTEN]};
    assign o_sequential_output = seq_out;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    a_seq_sel_lock:
    assert property ($past(ctrl_a[0][A_EN]) |-> $stable(seq_sel))
        else $error("sequential select changed while even table on");
    a_ctrl_b_lock:
    assert property (ctrl_a[1][A_EN] |=> $stable(ctrl_b[1]) && $stable(ctrl_c[1]))
        else $error("table control changed while enabled");
    a_disable_write:
    assert property (i_wr && i_wr_addr == OFS_LUT_BASE && ctrl_a[0][A_EN] && !i_wr_data[A_EN]
                     |=> ctrl_a[0][7:1] == $past(ctrl_a[0][7:1]) && !ctrl_a[0][A_EN])
        else $error("disabling write changed protected bits");
    a_truth_index:
    assert property (lut_direct[0] == truth[0][lif[0].in] && lut_direct[1] == truth[1][lif[1].in])
        else $error("table output not indexed truth bit");
    a_mask_low:
    assert property (ctrl_c[0][3:0] == SRC_MASK |-> !lif[0].in[2])
        else $error("masked input not low");
    a_seq_clear:
    assert property (!lut_en[0] |-> !o_sequential_output ##1 !seq_q)
        else $error("sequential not cleared while even table off");
    a_dff_load:
    assert property (lut_en[0] && seq_sel == SEQ_DFF && lut_tick[0] && lut_out[1]
                     ##1 lut_en[0] |-> seq_q == $past(lut_out[0]))
        else $error("flip-flop did not load data");
    a_jk_toggle:
    assert property (lut_en[0] && seq_sel == SEQ_JK && lut_tick[0] && lut_out[0] && lut_out[1]
                     ##1 lut_en[0] |-> seq_q != $past(seq_q))
        else $error("jk did not toggle");
    a_rs_hold:
    assert property (lut_en[0] && seq_sel == SEQ_RS && lut_out[0] && lut_out[1] |-> seq_out == seq_q)
        else $error("rs latch changed with both inputs set");
endmodule : ccl_top
`default_nettype wire

// File: tb/ccl_far_end.sv
// Far-end model: event channels, table pins and peripheral outputs
`timescale 1ns/1ps
`default_nettype none
module ccl_far_end (
    input wire logic i_clk,
    input wire logic [1:0] i_ev_cmd,
    input wire logic [5:0] i_pin_cmd,
    input wire logic [7:0] i_per_cmd,
    output logic o_event_line_a,
    output logic o_event_line_b,
    output logic [5:0] o_table_pin,
    output logic [7:0] o_periph
);
    // Known levels before the first edge
    initial begin
        o_event_line_a = 1'b0;
        o_event_line_b = 1'b0;
        o_table_pin = 6'h00;
        o_periph = 8'h00;
    end

    // Launch commanded levels just after each edge
    always @(posedge i_clk) begin
        o_event_line_a <= i_ev_cmd[0];
        o_event_line_b <= i_ev_cmd[1];
        o_table_pin <= i_pin_cmd;
        o_periph <= i_per_cmd;
    end
endmodule : ccl_far_end
`default_nettype wire

// File: tb/tb_ccl_top.sv
// Self-checking bench for the configurable lookup logic
`timescale 1ns/1ps
`default_nettype none
module tb_ccl_top;
    import ccl_pkg::*;
    // One table configuration with stimulus and expected output
    typedef struct packed {
        logic [7:0] b;
        logic [7:0] c;
        logic [7:0] truth;
        logic [1:0] ev;
        logic [5:0] pin;
        logic [7:0] per;
        logic exp;
    } ccl_row_s;
    localparam logic [3:0] T0A = OFS_LUT_BASE + OFS_CTRL_A; // Table 0 offsets
    localparam logic [3:0] T0B = OFS_LUT_BASE + OFS_CTRL_B;
    localparam logic [3:0] T0C = OFS_LUT_BASE + OFS_CTRL_C;
    localparam logic [3:0] T0T = OFS_LUT_BASE + OFS_TRUTH;
    localparam logic [3:0] T1A = T0A + OFS_LUT_STRIDE; // Table 1 offsets
    localparam logic [3:0] T1B = T0B + OFS_LUT_STRIDE;
    localparam logic [3:0] T1T = T0T + OFS_LUT_STRIDE;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_wr = 1'b0;
    logic [3:0] wa = 4'h0; // Write offset
    logic [3:0] ra = 4'h0; // Readback offset
    logic [7:0] wd = 8'h00; // Write data
    logic [7:0] rd; // Readback data
    logic [1:0] ev_cmd = 2'h0; // Far-end commands
    logic [5:0] pin_cmd = 6'h00;
    logic [7:0] per_cmd = 8'h00;
    logic ev_a;
    logic ev_b;
    logic [5:0] pins;
    logic [7:0] per;
    logic [1:0] tev; // Table output events
    logic [1:0] poe; // Pin output enables
    logic [1:0] pout; // Pin outputs
    logic sq; // Sequential output
    int fails = 0;
    int n_compared = 0;

    // 200 MHz clock
    always #2.5 i_clk = ~i_clk;

    ccl_top u_ccl_top (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wr(i_wr), .i_wr_addr(wa), .i_wr_data(wd),
        .i_rd_addr(ra), .o_rd_data(rd), .i_event_line_a(ev_a), .i_event_line_b(ev_b), .i_table_pin(pins),
        .i_periph(per), .o_table_output_event(tev), .o_pin_out(pout), .o_pin_oe(poe), .o_sequential_output(sq));
    ccl_far_end u_ccl_far_end (.i_clk(i_clk), .i_ev_cmd(ev_cmd), .i_pin_cmd(pin_cmd), .i_per_cmd(per_cmd),
        .o_event_line_a(ev_a), .o_event_line_b(ev_b), .o_table_pin(pins), .o_periph(per));

    // Compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        wa <= a;
        wd <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    // Registered readback and compare
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        ra <= a;
        repeat (2) @(posedge i_clk);
        #1 chk(rd, exp);
    endtask : rd_chk

    // Let outputs settle past n edges
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : wait_cyc

    // Print counts and verdict, then stop
    task automatic complete_run();
        $display("Counts: %0d compared, %0d failed", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge i_clk);
        fails++;
        complete_run();
    end

    // Main sequence
    initial begin
        ccl_row_s rows [11];
        int k;
        int hi;
        logic s;
        rows = '{'{8'h76, 8'h08, 8'hB4, 2'h0, 6'h00, 8'h03, 1'b0}, '{8'h76, 8'h08, 8'hB4, 2'h0, 6'h00, 8'h05, 1'b1},
            '{8'h76, 8'h08, 8'hB4, 2'h0, 6'h00, 8'h07, 1'b1}, '{8'h76, 8'h08, 8'hB4, 2'h0, 6'h00, 8'h02, 1'b1},
            '{8'h76, 8'h08, 8'hB4, 2'h0, 6'h00, 8'h00, 1'b0}, '{8'h00, 8'h00, 8'h01, 2'h3, 6'h3F, 8'hFF, 1'b1},
            '{8'h03, 8'h00, 8'h02, 2'h1, 6'h00, 8'h00, 1'b1}, '{8'h04, 8'h00, 8'h02, 2'h1, 6'h00, 8'h00, 1'b0},
            '{8'h04, 8'h00, 8'h02, 2'h2, 6'h00, 8'h00, 1'b1}, '{8'h00, 8'h05, 8'h10, 2'h0, 6'h04, 8'h00, 1'b1},
            '{8'h02, 8'h00, 8'h02, 2'h0, 6'h00, 8'h00, 1'b1}};
        wait_cyc(12);
        chk({3'h0, sq, poe, tev}, 8'h00);
        i_sys_rst <= 1'b0;
        rd_chk(OFS_SEQ, {4'h0, RST_SEQ});
        wr(OFS_CTRL, 8'h01);
        wr(T1T, 8'hFF);
        wr(T1A, 8'h01);
        // Table rows: stimulus set before the source is selected
        foreach (rows[i]) begin
            ev_cmd <= rows[i].ev;
            pin_cmd <= rows[i].pin;
            per_cmd <= rows[i].per;
            wr(T0A, 8'h00);
            wr(T0B, rows[i].b);
            wr(T0C, rows[i].c);
            wr(T0T, rows[i].truth);
            wr(T0A, 8'h01);
            wait_cyc(6);
            chk({7'h0, tev[0]}, {7'h0, rows[i].exp});
            chk({6'h0, pout[0], tev[1]}, {6'h0, rows[i].exp, 1'b1});
        end
        // Locked fields while table 0 runs
        wr(T0B, 8'h55);
        rd_chk(T0B, 8'h02);
        wr(OFS_SEQ, {4'h0, SEQ_DFF});
        rd_chk(OFS_SEQ, 8'h00);
        wr(T0A, 8'h08);
        rd_chk(T0A, 8'h00);
        wr(T0A, 8'h09);
        rd_chk(T0A, 8'h09);
        chk({6'h0, poe}, 8'h01);
        wr(OFS_CTRL, 8'h00);
        wait_cyc(2);
        chk({6'h0, poe}, 8'h00);
        wr(OFS_CTRL, 8'h01);
        // Delay through synchronizer and filter
        for (int f = 1; f <= 2; f++) begin
            per_cmd <= 8'h00;
            wr(T0A, 8'h00);
            wr(T0B, 8'h06);
            wr(T0T, 8'hAA);
            wr(T0A, {2'b00, f[1:0], 4'h1});
            wait_cyc(8);
            per_cmd <= 8'h01;
            k = 0;
            while (tev[0] !== 1'b1 && k < 20) begin
                wait_cyc(1);
                k++;
            end
            chk({7'h0, k >= 3 && k <= 6}, 8'h01);
        end
        // Edge pulse, with the synchronizer behind it
        per_cmd <= 8'h00;
        wr(T0A, 8'h00);
        wr(T0A, 8'h91);
        wait_cyc(8);
        per_cmd <= 8'h01;
        hi = 0;
        for (int j = 0; j < 10; j++) begin
            wait_cyc(1);
            if (tev[0] === 1'b1) hi++;
        end
        chk(8'(hi), 8'h01);
        // JK element from both tables
        per_cmd <= 8'h00;
        wr(T0A, 8'h00);
        wr(T1A, 8'h00);
        wr(OFS_SEQ, {4'h0, SEQ_JK});
        rd_chk(OFS_SEQ, {4'h0, SEQ_JK});
        wr(T1B, 8'h06);
        wr(T1T, 8'hAA);
        wr(T0A, 8'h01);
        wr(T1A, 8'h01);
        per_cmd <= 8'h01;
        wait_cyc(4);
        chk({7'h0, sq}, 8'h01);
        per_cmd <= 8'h00;
        wait_cyc(4);
        chk({7'h0, sq}, 8'h01);
        per_cmd <= 8'h10;
        wait_cyc(4);
        chk({7'h0, sq}, 8'h00);
        per_cmd <= 8'h11;
        wait_cyc(4);
        s = sq;
        wait_cyc(1);
        chk({7'h0, sq}, {7'h0, ~s});
        per_cmd <= 8'h01;
        wait_cyc(4);
        chk({7'h0, sq}, 8'h01);
        // Gated flop then gated latch: data from table 0, gate from table 1
        for (int m = 1; m <= 3; m += 2) begin
            wr(T0A, 8'h00);
            wr(OFS_SEQ, 8'(m));
            wr(T0A, 8'h01);
            per_cmd <= 8'h11;
            wait_cyc(4);
            chk({7'h0, sq}, 8'h01);
            per_cmd <= 8'h10;
            wait_cyc(4);
            chk({7'h0, sq}, 8'h00);
            per_cmd <= 8'h01;
            wait_cyc(4);
            chk({7'h0, sq}, 8'h00);
        end
        // Set-reset latch: set from table 0, reset from table 1
        wr(T0A, 8'h00);
        wr(OFS_SEQ, {4'h0, SEQ_RS});
        wr(T0A, 8'h01);
        per_cmd <= 8'h01;
        wait_cyc(4);
        chk({7'h0, sq}, 8'h01);
        per_cmd <= 8'h11;
        wait_cyc(4);
        chk({7'h0, sq}, 8'h01);
        per_cmd <= 8'h10;
        wait_cyc(4);
        chk({7'h0, sq}, 8'h00);
        per_cmd <= 8'h01;
        wait_cyc(4);
        chk({7'h0, sq}, 8'h01);
        // Table 1 reads the pair state back through its feedback input
        wr(T1A, 8'h00);
        wr(T1B, 8'h01);
        wr(T1T, 8'h02);
        wr(T1A, 8'h01);
        wait_cyc(2);
        chk({6'h0, tev[1], sq}, 8'h03);
        wr(T0A, 8'h00);
        wait_cyc(2);
        chk({6'h0, tev[1], sq}, 8'h00);
        complete_run();
    end
endmodule : tb_ccl_top
`default_nettype wire
